// ### ccr_pkg.sv
// ccr_pkg: constants for the core control and system register set
// assumes: referenced by ccr_regs, its checker and the test; no imports anywhere
package ccr_pkg;
   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int WORD_W = 32;
   localparam int ACC_W = 40;
   localparam int GUARD_W = 8;
   localparam int HALF_W = 16;

   // ------------------------------------------------------------
   // register select codes for load/store control and system ops
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      CCR_SEL_PSW,
      CCR_SEL_LSTART,
      CCR_SEL_LEND,
      CCR_SEL_PBASE,
      CCR_SEL_VBASE,
      CCR_SEL_WRAP,
      CCR_SEL_PHI,
      CCR_SEL_PLO,
      CCR_SEL_LINK,
      CCR_SEL_PADDR,
      CCR_SEL_ACC
   } ccr_sel_t;

   // ------------------------------------------------------------
   // status word field positions
   // ------------------------------------------------------------
   localparam int PSW_CNT_HI = 27;
   localparam int PSW_CNT_LO = 16;
   localparam int PSW_YWRAP = 11;
   localparam int PSW_XWRAP = 10;
   localparam int PSW_M = 9;
   localparam int PSW_Q = 8;
   localparam int PSW_LVL_HI = 7;
   localparam int PSW_LVL_LO = 4;
   localparam int PSW_RF_HI = 3;
   localparam int PSW_RF_LO = 2;
   localparam int PSW_SAT = 1;
   localparam int PSW_T = 0;
   localparam logic [31:0] PSW_WMASK = 32'h0FFF_0FFF;
   localparam logic [31:0] PSW_RESET = 32'h0000_00F0;

   // ------------------------------------------------------------
   // loop length flag codes and step/offset constants
   // ------------------------------------------------------------
   localparam logic [1:0] RF_ONE = 2'h0;
   localparam logic [1:0] RF_TWO = 2'h1;
   localparam logic [1:0] RF_THREE = 2'h3;
   localparam logic [1:0] RF_MANY = 2'h2;
   localparam logic [31:0] MEM_STEP = 32'h0000_0004;
   localparam logic [31:0] PC_AHEAD = 32'h0000_0004;
   localparam logic [15:0] PTR_STEP = 16'h0002;
   localparam logic [11:0] CNT_ONE = 12'h001;
   localparam logic [11:0] CNT_ZERO = 12'h000;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage

// ### ccr_regs.sv
// ccr_regs: control and system registers of the core with loop and wrap logic
// assumes: the decode stage drives one-cycle op strobes on clk, all same domain
//
// Behaviour
// - six 32-bit control registers: status, loop start/end, periph base, vector base, wrap
// - peripheral base pointer plus displacement forms base-relative peripheral address
// - exception vector address is computed relative to vector table base
// - status bits 27..16 hold loop count, valid 2 to 4095
// - loop pointers hold encoded addresses, read with loop length flags
// - wrap register: end address upper 16 bits, start address lower 16
// - wrap applies to paired X/Y transfers only, never single transfers
// - status bit 11 enables wrap for Y pointers R6 and R7
// - status bit 10 enables wrap for X pointers R4 and R5
// - status bits 9 and 8 are divide flags read and updated by divide ops
// - status bits 7..4 are interrupt acceptance level compared with requests
// - set loop count writes flags 00, 01, 11, 10 for 1, 2, 3, 4+ steps
// - status bit 1 makes multiply-accumulate and signal arithmetic saturate
// - status bit 0 records test result and carry, borrow, overflow
// - status bits 31..28 and 15..12 read zero; software writes zero
// - memory load reads then pointer plus 4; store predecrements pointer by 4
// - load loop start/end writes executing instruction address plus twice displacement
// - four 32-bit system registers: product high/low, link, program address
// - program address reads as executing instruction address plus 4
// - link captures return address on call; parallel multiply leaves product alone
// - accumulator read ignores guard; write copies msb into guard bits
// - accumulator is 40 bits: 8-bit guard above 32-bit data
// - reset: level 1111, reserved, count and wrap enables zero
`timescale 1ns/1ns
module ccr_regs
(
   input wire logic clk,
   input wire logic rst_b,
   // executing instruction address
   input wire logic [31:0] exec_addr,
   // register transfer port
   input wire logic ctl_wr,
   input wire logic ctl_rd,
   input wire ccr_pkg::ccr_sel_t ctl_sel,
   input wire logic [31:0] ctl_wdata,
   output logic [31:0] ctl_rdata,
   // memory forms of load/store control
   input wire logic load_control_op,
   input wire logic store_control_op,
   input wire logic [31:0] mem_ptr,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_ptr_next,
   // loop set-up ops
   input wire logic set_loop_count_op,
   input wire logic [11:0] loop_count_in,
   input wire logic [2:0] loop_steps,
   input wire logic load_loop_start_op,
   input wire logic load_loop_end_op,
   input wire logic [31:0] disp,
   output logic loop_branch,
   output logic [31:0] loop_target,
   // flag updates from the execute stage
   input wire logic t_we,
   input wire logic t_in,
   input wire logic divide_init_op,
   input wire logic divide_step_op,
   input wire logic m_in,
   input wire logic q_in,
   output logic m_flag,
   output logic q_flag,
   output logic t_flag,
   output logic sat_en,
   // interrupt level compare
   input wire logic [3:0] irq_priority,
   output logic irq_accept,
   // exception vector and peripheral addressing
   input wire logic [31:0] vector_offset,
   output logic [31:0] vector_addr,
   input wire logic [31:0] periph_disp,
   output logic [31:0] periph_addr,
   // product and link updates
   input wire logic multiply_accumulate_op,
   input wire logic parallel_multiply_op,
   input wire logic [31:0] product_hi_in,
   input wire logic [31:0] product_lo_in,
   input wire logic call_op,
   input wire logic [31:0] return_addr,
   // data pointer update through the wrap units
   input wire logic paired_x_transfer,
   input wire logic paired_y_transfer,
   input wire logic single_transfer,
   input wire logic [31:0] x_ptr,
   input wire logic [31:0] y_ptr,
   input wire logic [31:0] ptr_step,
   output logic [31:0] x_ptr_next,
   output logic [31:0] y_ptr_next,
   output logic [39:0] accumulator_zero
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [31:0] psw_q;
   logic [31:0] loop_start_q;
   logic [31:0] loop_end_q;
   logic [31:0] pbase_q;
   logic [31:0] vbase_q;
   logic [31:0] wrap_q;
   logic [31:0] phi_q;
   logic [31:0] plo_q;
   logic [31:0] link_q;
   logic [39:0] acc_q;
   logic [31:0] rdata_d;
   logic [31:0] wr_val;
   logic wr_any;
   logic [11:0] loop_cnt;
   logic at_loop_end;
   logic [1:0] rf_code;
   logic [15:0] wrap_start;
   logic [15:0] wrap_end;
   logic x_wrap_en;
   logic y_wrap_en;

   assign loop_cnt = psw_q[ccr_pkg::PSW_CNT_HI:ccr_pkg::PSW_CNT_LO];
   // memory loads use the word at the pointer; stores write to the predecremented one
   assign mem_addr = store_control_op ? mem_ptr - ccr_pkg::MEM_STEP : mem_ptr;
   assign mem_ptr_next = store_control_op ? mem_ptr - ccr_pkg::MEM_STEP
                                          : mem_ptr + ccr_pkg::MEM_STEP;
   assign wr_any = ctl_wr | load_control_op;
   assign wr_val = ctl_wdata;

   // ------------------------------------------------------------
   // loop hardware
   // ------------------------------------------------------------
   // a loop is live while the count is above zero; the encoded end pointer is
   // compared directly, so the caller presents the matching encoded address
   assign at_loop_end = (loop_cnt != ccr_pkg::CNT_ZERO) && (exec_addr == loop_end_q);
   assign loop_branch = at_loop_end && (loop_cnt != ccr_pkg::CNT_ONE);
   assign loop_target = loop_start_q;

   always_comb
   begin
      unique case (loop_steps)
         3'h1: rf_code = ccr_pkg::RF_ONE;
         3'h2: rf_code = ccr_pkg::RF_TWO;
         3'h3: rf_code = ccr_pkg::RF_THREE;
         default: rf_code = ccr_pkg::RF_MANY;
      endcase
   end

   // ------------------------------------------------------------
   // status word
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         psw_q <= ccr_pkg::PSW_RESET;
      else if (wr_any && ctl_sel == ccr_pkg::CCR_SEL_PSW)
         psw_q <= wr_val & ccr_pkg::PSW_WMASK;
      else
      begin
         if (set_loop_count_op)
         begin
            psw_q[ccr_pkg::PSW_CNT_HI:ccr_pkg::PSW_CNT_LO] <= loop_count_in;
            psw_q[ccr_pkg::PSW_RF_HI:ccr_pkg::PSW_RF_LO] <= rf_code;
         end
         else if (at_loop_end)
            psw_q[ccr_pkg::PSW_CNT_HI:ccr_pkg::PSW_CNT_LO] <= loop_cnt - ccr_pkg::CNT_ONE;
         if (divide_init_op || divide_step_op)
         begin
            psw_q[ccr_pkg::PSW_M] <= m_in;
            psw_q[ccr_pkg::PSW_Q] <= q_in;
         end
         if (t_we)
            psw_q[ccr_pkg::PSW_T] <= t_in;
      end
   end

   assign m_flag = psw_q[ccr_pkg::PSW_M];
   assign q_flag = psw_q[ccr_pkg::PSW_Q];
   assign t_flag = psw_q[ccr_pkg::PSW_T];
   assign sat_en = psw_q[ccr_pkg::PSW_SAT];
   // requests must exceed the level; level 15 after reset blocks all
   assign irq_accept = irq_priority > psw_q[ccr_pkg::PSW_LVL_HI:ccr_pkg::PSW_LVL_LO];

   // ------------------------------------------------------------
   // loop pointers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         loop_start_q <= ccr_pkg::ZERO32;
      else if (load_loop_start_op)
         loop_start_q <= exec_addr + {disp[30:0], 1'b0};
      else if (wr_any && ctl_sel == ccr_pkg::CCR_SEL_LSTART)
         loop_start_q <= wr_val;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         loop_end_q <= ccr_pkg::ZERO32;
      else if (load_loop_end_op)
         loop_end_q <= exec_addr + {disp[30:0], 1'b0};
      else if (wr_any && ctl_sel == ccr_pkg::CCR_SEL_LEND)
         loop_end_q <= wr_val;
   end

   // ------------------------------------------------------------
   // base pointers and wrap bounds
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         pbase_q <= ccr_pkg::ZERO32;
      else if (wr_any && ctl_sel == ccr_pkg::CCR_SEL_PBASE)
         pbase_q <= wr_val;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         vbase_q <= ccr_pkg::ZERO32;
      else if (wr_any && ctl_sel == ccr_pkg::CCR_SEL_VBASE)
         vbase_q <= wr_val;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         wrap_q <= ccr_pkg::ZERO32;
      else if (wr_any && ctl_sel == ccr_pkg::CCR_SEL_WRAP)
         wrap_q <= wr_val;
   end

   assign periph_addr = pbase_q + periph_disp;
   assign vector_addr = vbase_q + vector_offset;

   // ------------------------------------------------------------
   // product, link and accumulator
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         phi_q <= ccr_pkg::ZERO32;
      else if (multiply_accumulate_op && !parallel_multiply_op)
         phi_q <= product_hi_in;
      else if (wr_any && ctl_sel == ccr_pkg::CCR_SEL_PHI)
         phi_q <= wr_val;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         plo_q <= ccr_pkg::ZERO32;
      else if (multiply_accumulate_op && !parallel_multiply_op)
         plo_q <= product_lo_in;
      else if (wr_any && ctl_sel == ccr_pkg::CCR_SEL_PLO)
         plo_q <= wr_val;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         link_q <= ccr_pkg::ZERO32;
      else if (call_op)
         link_q <= return_addr;
      else if (wr_any && ctl_sel == ccr_pkg::CCR_SEL_LINK)
         link_q <= wr_val;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         acc_q <= {ccr_pkg::ACC_W{1'b0}};
      else if (wr_any && ctl_sel == ccr_pkg::CCR_SEL_ACC)
         acc_q <= {{ccr_pkg::GUARD_W{wr_val[ccr_pkg::WORD_W-1]}}, wr_val};
   end

   assign accumulator_zero = acc_q;

   // ------------------------------------------------------------
   // read mux, registered data
   // ------------------------------------------------------------
   always_comb
   begin
      unique case (ctl_sel)
         ccr_pkg::CCR_SEL_PSW: rdata_d = psw_q & ccr_pkg::PSW_WMASK;
         ccr_pkg::CCR_SEL_LSTART: rdata_d = loop_start_q;
         ccr_pkg::CCR_SEL_LEND: rdata_d = loop_end_q;
         ccr_pkg::CCR_SEL_PBASE: rdata_d = pbase_q;
         ccr_pkg::CCR_SEL_VBASE: rdata_d = vbase_q;
         ccr_pkg::CCR_SEL_WRAP: rdata_d = wrap_q;
         ccr_pkg::CCR_SEL_PHI: rdata_d = phi_q;
         ccr_pkg::CCR_SEL_PLO: rdata_d = plo_q;
         ccr_pkg::CCR_SEL_LINK: rdata_d = link_q;
         ccr_pkg::CCR_SEL_PADDR: rdata_d = exec_addr + ccr_pkg::PC_AHEAD;
         ccr_pkg::CCR_SEL_ACC: rdata_d = acc_q[ccr_pkg::WORD_W-1:0];
         default: rdata_d = ccr_pkg::ZERO32;
      endcase
   end

   // same path serves the register and memory store forms
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         ctl_rdata <= ccr_pkg::ZERO32;
      else if (ctl_rd || store_control_op)
         ctl_rdata <= rdata_d;
   end

   // ------------------------------------------------------------
   // data pointer wrap; single transfers never wrap
   // ------------------------------------------------------------
   // if software sets both enables the units still work independently,
   // the result is simply undefined use
   assign wrap_start = wrap_q[ccr_pkg::HALF_W-1:0];
   assign wrap_end = wrap_q[ccr_pkg::WORD_W-1:ccr_pkg::HALF_W];
   // only the paired transfers on the x and y pointer pairs see the bounds
   assign x_wrap_en = psw_q[ccr_pkg::PSW_XWRAP] && paired_x_transfer && !single_transfer;
   assign y_wrap_en = psw_q[ccr_pkg::PSW_YWRAP] && paired_y_transfer && !single_transfer;

   ccr_wrap_unit u_xwrap
   (
      .ptr(x_ptr),
      .step(ptr_step),
      .wrap_en(x_wrap_en),
      .wrap_start(wrap_start),
      .wrap_end(wrap_end),
      .next_ptr(x_ptr_next)
   );

   ccr_wrap_unit u_ywrap
   (
      .ptr(y_ptr),
      .step(ptr_step),
      .wrap_en(y_wrap_en),
      .wrap_start(wrap_start),
      .wrap_end(wrap_end),
      .next_ptr(y_ptr_next)
   );
endmodule

// ### ccr_regs_checker.sv
// ccr_regs_checker: port-level assertions for the control register set
// assumes: bound into ccr_regs, one clk domain, rst_b async active low
`timescale 1ns/1ns
module ccr_regs_checker
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [31:0] exec_addr,
   input wire logic ctl_wr,
   input wire logic ctl_rd,
   input wire ccr_pkg::ccr_sel_t ctl_sel,
   input wire logic [31:0] ctl_wdata,
   input wire logic [31:0] ctl_rdata,
   input wire logic load_control_op,
   input wire logic store_control_op,
   input wire logic [31:0] mem_ptr,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_ptr_next,
   input wire logic load_loop_start_op,
   input wire logic [31:0] disp,
   input wire logic [31:0] loop_target,
   input wire logic irq_accept,
   input wire logic [39:0] accumulator_zero
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   property p_load_ptr;
      load_control_op && !store_control_op |-> mem_addr == mem_ptr && mem_ptr_next == mem_ptr + 32'h4;
   endproperty
   property p_store_ptr;
      store_control_op && !load_control_op |-> mem_addr == mem_ptr - 32'h4 && mem_ptr_next == mem_addr;
   endproperty
   property p_pc_read;
      ctl_rd && ctl_sel == ccr_pkg::CCR_SEL_PADDR |=> ctl_rdata == $past(exec_addr) + 32'h4;
   endproperty
   property p_psw_zero;
      (ctl_rd || store_control_op) && ctl_sel == ccr_pkg::CCR_SEL_PSW |=> (ctl_rdata & ~ccr_pkg::PSW_WMASK) == 0;
   endproperty
   property p_acc_write;
      (ctl_wr || load_control_op) && ctl_sel == ccr_pkg::CCR_SEL_ACC
         |=> accumulator_zero == {{8{$past(ctl_wdata[31])}}, $past(ctl_wdata)};
   endproperty
   property p_acc_read;
      ctl_rd && !ctl_wr && !load_control_op && ctl_sel == ccr_pkg::CCR_SEL_ACC
         |=> ctl_rdata == $past(accumulator_zero[31:0]);
   endproperty
   // a wrap register write followed straight by a read must give the data back unchanged
   property p_wrap_rw;
      ctl_wr && ctl_sel == ccr_pkg::CCR_SEL_WRAP ##1 ctl_rd && !ctl_wr && !load_control_op
         && ctl_sel == ccr_pkg::CCR_SEL_WRAP |=> ctl_rdata == $past(ctl_wdata, 2);
   endproperty
   property p_loop_start;
      load_loop_start_op |=> loop_target == $past(exec_addr) + {$past(disp[30:0]), 1'b0};
   endproperty
   // level 1111 after reset: no priority can exceed it
   property p_irq_reset;
      $rose(rst_b) |-> !irq_accept;
   endproperty
   // ------------------------------------------------------------
   // assertions and covers
   // ------------------------------------------------------------
   a_load_ptr: assert property (p_load_ptr) else $error("load pointer step wrong");
   a_store_ptr: assert property (p_store_ptr) else $error("store pointer step wrong");
   a_pc_read: assert property (p_pc_read) else $error("program address read wrong");
   a_psw_zero: assert property (p_psw_zero) else $error("status zero bits set");
   a_acc_write: assert property (p_acc_write) else $error("guard not sign copy");
   a_acc_read: assert property (p_acc_read) else $error("accumulator read wrong");
   a_wrap_rw: assert property (p_wrap_rw) else $error("wrap bounds readback wrong");
   a_loop_start: assert property (p_loop_start) else $error("loop start wrong");
   a_irq_reset: assert property (p_irq_reset) else $error("irq accepted after reset");
   c_pc: cover property (ctl_rd && ctl_sel == ccr_pkg::CCR_SEL_PADDR);
   c_loop: cover property (load_loop_start_op);
   c_irq: cover property (irq_accept);
endmodule

bind ccr_regs ccr_regs_checker u_ccr_regs_checker (.clk(clk), .rst_b(rst_b), .exec_addr(exec_addr),
   .ctl_wr(ctl_wr), .ctl_rd(ctl_rd), .ctl_sel(ctl_sel), .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata),
   .load_control_op(load_control_op), .store_control_op(store_control_op), .mem_ptr(mem_ptr),
   .mem_addr(mem_addr), .mem_ptr_next(mem_ptr_next), .load_loop_start_op(load_loop_start_op),
   .disp(disp), .loop_target(loop_target), .irq_accept(irq_accept), .accumulator_zero(accumulator_zero));

// ### ccr_wrap_unit.sv
// ccr_wrap_unit: next value of one data address pointer with modulo wrap
// assumes: bounds come from the wraparound register, same clock as caller
`timescale 1ns/1ns
module ccr_wrap_unit
(
   input wire logic [31:0] ptr,
   input wire logic [31:0] step,
   input wire logic wrap_en,
   input wire logic [15:0] wrap_start,
   input wire logic [15:0] wrap_end,
   output logic [31:0] next_ptr
);
   always_comb
   begin
      // wrap compares only the low half; upper bits keep the page
      if (wrap_en && (ptr[15:0] == wrap_end))
         next_ptr = {ptr[31:16], wrap_start};
      else
         next_ptr = ptr + step;
   end
endmodule

// ### cpu_control_system_registers_test.sv
// cpu_control_system_registers_test: directed bench for ccr_regs
// assumes: ccr_pkg compiled first, checker bound separately
`timescale 1ns/1ns
module cpu_control_system_registers_test;
   logic clk = 0;
   logic rst_b = 0;
   logic ctl_wr = 0, ctl_rd = 0, load_control_op = 0, store_control_op = 0, set_loop_count_op = 0;
   logic load_loop_start_op = 0, load_loop_end_op = 0, t_we = 0, t_in = 0, divide_init_op = 0;
   logic divide_step_op = 0, m_in = 0, q_in = 0, multiply_accumulate_op = 0, parallel_multiply_op = 0;
   logic call_op = 0, paired_x_transfer = 0, paired_y_transfer = 0, single_transfer = 0;
   logic [31:0] exec_addr = 0, ctl_wdata = 0, mem_ptr = 0, disp = 0, vector_offset = 0, periph_disp = 0;
   logic [31:0] product_hi_in = 0, product_lo_in = 0, return_addr = 0, x_ptr = 0, y_ptr = 0, ptr_step = 0;
   logic [11:0] loop_count_in = 0;
   logic [2:0] loop_steps = 0;
   logic [3:0] irq_priority = 0;
   ccr_pkg::ccr_sel_t ctl_sel = ccr_pkg::CCR_SEL_PSW;
   logic [31:0] ctl_rdata, mem_addr, mem_ptr_next, loop_target, vector_addr, periph_addr, x_ptr_next, y_ptr_next;
   logic loop_branch, m_flag, q_flag, t_flag, sat_en, irq_accept;
   logic [39:0] accumulator_zero;
   logic [1:0] flag_tbl [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
   int mismatches = 0;
   int n_tests = 0;

   ccr_regs u_ccr_regs (.clk, .rst_b, .exec_addr, .ctl_wr, .ctl_rd, .ctl_sel, .ctl_wdata, .ctl_rdata,
      .load_control_op, .store_control_op, .mem_ptr, .mem_addr, .mem_ptr_next, .set_loop_count_op,
      .loop_count_in, .loop_steps, .load_loop_start_op, .load_loop_end_op, .disp, .loop_branch, .loop_target,
      .t_we, .t_in, .divide_init_op, .divide_step_op, .m_in, .q_in, .m_flag, .q_flag, .t_flag, .sat_en,
      .irq_priority, .irq_accept, .vector_offset, .vector_addr, .periph_disp, .periph_addr,
      .multiply_accumulate_op, .parallel_multiply_op, .product_hi_in, .product_lo_in, .call_op, .return_addr,
      .paired_x_transfer, .paired_y_transfer, .single_transfer, .x_ptr, .y_ptr, .ptr_step, .x_ptr_next,
      .y_ptr_next, .accumulator_zero);

   always #25 clk = ~clk;

   // ------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // inputs move at least 5 ns after the edge so the design never races them
   task automatic step();
      @(posedge clk);
      #5;
   endtask
   task automatic wr(input ccr_pkg::ccr_sel_t s, input logic [31:0] d);
      ctl_wr = 1;
      ctl_sel = s;
      ctl_wdata = d;
      step();
      ctl_wr = 0;
   endtask
   task automatic rd(input ccr_pkg::ccr_sel_t s, input logic [31:0] e);
      ctl_rd = 1;
      ctl_sel = s;
      step();
      ctl_rd = 0;
      chk(ctl_rdata, e);
   endtask
   task automatic print_verdict();
      if (mismatches == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      repeat (5000) @(posedge clk);
      mismatches++;
      print_verdict();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge clk);
      #5;
      rst_b = 1;
      irq_priority = 4'hF;
      rd(ccr_pkg::CCR_SEL_PSW, 32'h0000_00F0);
      chk(irq_accept, 0);
      wr(ccr_pkg::CCR_SEL_PSW, 32'hFFFF_F7FF);
      rd(ccr_pkg::CCR_SEL_PSW, 32'h0FFF_07FF);
      chk({sat_en, t_flag}, 2'h3);
      wr(ccr_pkg::CCR_SEL_PSW, 32'h0000_0050);
      irq_priority = 4'h6;
      #1 chk(irq_accept, 1);
      irq_priority = 4'h5;
      #1 chk(irq_accept, 0);
      for (int i = 1; i < 9; i++)
         wr(ccr_pkg::ccr_sel_t'(i), {28'hA500000, i[3:0]});
      for (int i = 1; i < 9; i++)
         rd(ccr_pkg::ccr_sel_t'(i), {28'hA500000, i[3:0]});
      rd(ccr_pkg::ccr_sel_t'(4'hF), 32'h0);
      exec_addr = 32'h0000_1000;
      rd(ccr_pkg::CCR_SEL_PADDR, 32'h0000_1004);
      periph_disp = 32'h10;
      vector_offset = 32'h20;
      #1 chk(periph_addr, 32'hA500_0013);
      chk(vector_addr, 32'hA500_0024);
      // x wrap on: x folds back to start, y keeps counting
      wr(ccr_pkg::CCR_SEL_WRAP, 32'h0010_0000);
      rd(ccr_pkg::CCR_SEL_WRAP, 32'h0010_0000);
      wr(ccr_pkg::CCR_SEL_PSW, 32'h0000_0400);
      x_ptr = 32'h0001_0010;
      y_ptr = 32'h0001_0010;
      ptr_step = 32'h2;
      paired_x_transfer = 1;
      paired_y_transfer = 1;
      #1 chk({x_ptr_next, y_ptr_next}, {32'h0001_0000, 32'h0001_0012});
      step();
      paired_x_transfer = 0;
      paired_y_transfer = 0;
      single_transfer = 1;
      #1 chk(x_ptr_next, 32'h0001_0012);
      step();
      single_transfer = 0;
      paired_y_transfer = 1;
      wr(ccr_pkg::CCR_SEL_PSW, 32'h0000_0800);
      chk({x_ptr_next, y_ptr_next}, {32'h0001_0012, 32'h0001_0000});
      paired_y_transfer = 0;
      mem_ptr = 32'h2000;
      load_control_op = 1;
      ctl_sel = ccr_pkg::CCR_SEL_VBASE;
      ctl_wdata = 32'h1234_5678;
      #1 chk({mem_addr, mem_ptr_next}, {32'h2000, 32'h2004});
      step();
      load_control_op = 0;
      rd(ccr_pkg::CCR_SEL_VBASE, 32'h1234_5678);
      store_control_op = 1;
      #1 chk({mem_addr, mem_ptr_next}, {32'h1FFC, 32'h1FFC});
      step();
      store_control_op = 0;
      chk(ctl_rdata, 32'h1234_5678);
      for (int i = 1; i < 5; i++)
      begin
         set_loop_count_op = 1;
         loop_count_in = 12'hFFF;
         loop_steps = i[2:0];
         step();
         set_loop_count_op = 0;
         rd(ccr_pkg::CCR_SEL_PSW, {16'h0FFF, 8'h08, 4'h0, flag_tbl[i - 1], 2'h0});
      end
      exec_addr = 32'h100;
      disp = 32'h8;
      load_loop_start_op = 1;
      step();
      load_loop_start_op = 0;
      exec_addr = 32'h130;
      disp = 32'h0;
      load_loop_end_op = 1;
      step();
      load_loop_end_op = 0;
      exec_addr = 32'h200;
      rd(ccr_pkg::CCR_SEL_LSTART, 32'h110);
      rd(ccr_pkg::CCR_SEL_LEND, 32'h130);
      set_loop_count_op = 1;
      loop_count_in = 12'h002;
      step();
      set_loop_count_op = 0;
      exec_addr = 32'h130;
      #1 chk({loop_branch, loop_target}, {1'b1, 32'h110});
      step();
      chk(loop_branch, 0);
      exec_addr = 32'h200;
      rd(ccr_pkg::CCR_SEL_PSW, {16'h0001, 8'h08, 4'h0, 2'h2, 2'h0});
      divide_init_op = 1;
      m_in = 1;
      step();
      divide_init_op = 0;
      divide_step_op = 1;
      chk({m_flag, q_flag}, 2'h2);
      m_in = 0;
      q_in = 1;
      t_we = 1;
      t_in = 1;
      step();
      divide_step_op = 0;
      t_we = 0;
      chk({m_flag, q_flag, t_flag}, 3'h3);
      multiply_accumulate_op = 1;
      product_hi_in = 32'h11;
      product_lo_in = 32'h22;
      step();
      parallel_multiply_op = 1;
      product_hi_in = 32'h33;
      call_op = 1;
      return_addr = 32'h3000;
      step();
      multiply_accumulate_op = 0;
      parallel_multiply_op = 0;
      call_op = 0;
      rd(ccr_pkg::CCR_SEL_PHI, 32'h11);
      rd(ccr_pkg::CCR_SEL_PLO, 32'h22);
      rd(ccr_pkg::CCR_SEL_LINK, 32'h3000);
      wr(ccr_pkg::CCR_SEL_ACC, 32'h8000_0001);
      chk(accumulator_zero, 40'hFF_8000_0001);
      rd(ccr_pkg::CCR_SEL_ACC, 32'h8000_0001);
      wr(ccr_pkg::CCR_SEL_ACC, 32'h7FFF_FFFF);
      chk(accumulator_zero, 40'h00_7FFF_FFFF);
      print_verdict();
   end
endmodule
